/* hw/rps_pkg.sv */
// Package: constants, register map and state codes of the regulator power sequencer
package rps_pkg;

  // Sequenced outputs and slot field width
  localparam int          NUM_REG   = 7;
  localparam int          SLOT_W    = 3;
  localparam logic [6:0]  ALL_REGS  = 7'h7F;

  // Clock rate and documented times
  localparam int          CLK_KHZ       = 25000;
  localparam int          SLOT_FAST_US  = 500;
  localparam int          SLOT_SLOW_US  = 2000;
  localparam int          PDN_GAP_US    = 2000;
  localparam int          REL_STEP_US   = 2000;
  localparam logic [15:0] SLOT_FAST_CYC = 16'(SLOT_FAST_US * CLK_KHZ / 1000);
  localparam logic [15:0] SLOT_SLOW_CYC = 16'(SLOT_SLOW_US * CLK_KHZ / 1000);
  localparam logic [15:0] PDN_GAP_CYC   = 16'(PDN_GAP_US * CLK_KHZ / 1000);
  localparam logic [15:0] REL_STEP_CYC  = 16'(REL_STEP_US * CLK_KHZ / 1000);

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_STBY_EN  = 8'h08;
  localparam logic [7:0] ADDR_SLEEP_EN = 8'h0C;
  localparam logic [7:0] ADDR_PDN_BASE = 8'h10;
  localparam logic [7:0] ADDR_PDN_LAST = 8'h28;

  // Field positions
  localparam int STAT_UP_BIT  = 0;
  localparam int STAT_DN_BIT  = 1;
  localparam int STAT_RST_BIT = 2;
  localparam int STAT_RTC_BIT = 3;

  // Reset values of the writable masks
  localparam logic [6:0] STBY_EN_RST  = 7'h7F;
  localparam logic [6:0] SLEEP_EN_RST = 7'h00;

  // Mode request codes written to the control register
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_RUN   = 2'h1;
  localparam logic [1:0] MODE_STBY  = 2'h2;
  localparam logic [1:0] MODE_SLEEP = 2'h3;

  // Sequencer states
  typedef enum logic [2:0] {
    PS_OFF   = 3'b000,
    PS_UP    = 3'b001,
    PS_RUN   = 3'b010,
    PS_DOWN  = 3'b011,
    PS_STBY  = 3'b100,
    PS_SLEEP = 3'b101
  } rps_state_t;

  // Reset release delay in 2 ms steps for each select code
  function automatic logic [9:0] rps_rel_steps(input logic [2:0] sel);
    logic [9:0] r;
    r = 10'h001;
    unique case (sel)
      3'h0: r = 10'h001;
      3'h1: r = 10'h002;
      3'h2: r = 10'h004;
      3'h3: r = 10'h008;
      3'h4: r = 10'h010;
      3'h5: r = 10'h020;
      3'h6: r = 10'h100;
      3'h7: r = 10'h200;
    endcase
    return r;
  endfunction

endpackage

/* hw/rps_tick.sv */
// Restartable tick generator for slot and gap timing
`timescale 1ns/1ps
module rps_tick
  import rps_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Control
  input  wire logic        restart,
  input  wire logic [15:0] period,
  // Output
  output logic             tick
);

  logic [15:0] cnt_reg; // Cycles elapsed in current period

  // Count cycles; restart realigns the period to a state change
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 16'h0000;
    end else if (restart || tick) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Pulse at the end of each period; zero period is treated as one cycle
  assign tick = !restart && (cnt_reg + 16'h0001 >= period);

endmodule // rps_tick

/* hw/rps_slot_match.sv */
// Slot comparator: which masked outputs sit in a slot, and the highest masked slot
`timescale 1ns/1ps
module rps_slot_match
  import rps_pkg::*;
(
  // Inputs
  input  wire logic [20:0] slots,
  input  wire logic [6:0]  mask,
  input  wire logic [2:0]  cmp,
  // Outputs
  output logic      [6:0]  match,
  output logic      [2:0]  max_slot
);

  // Per-output compare
  genvar g;
  generate
    for (g = 0; g < NUM_REG; g++) begin : g_cmp
      assign match[g] = mask[g] && (slots[g*SLOT_W +: SLOT_W] == cmp);
    end
  endgenerate

  // Highest slot among masked outputs
  always_comb begin
    max_slot = 3'h0;
    for (int i = 0; i < NUM_REG; i++) begin
      if (mask[i] && slots[i*SLOT_W +: SLOT_W] > max_slot) begin
        max_slot = slots[i*SLOT_W +: SLOT_W];
      end
    end
  end

endmodule // rps_slot_match

/* hw/rps_sequencer.sv */
// Regulator power-up / power-down sequencer with host reset release and register port
`timescale 1ns/1ps
module rps_sequencer
  import rps_pkg::*;
#(
  parameter logic [15:0] SLOT_FAST = SLOT_FAST_CYC, // 0.5 ms slot
  parameter logic [15:0] SLOT_SLOW = SLOT_SLOW_CYC, // 2.0 ms slot
  parameter logic [15:0] PDN_GAP   = PDN_GAP_CYC,   // 2.0 ms turn-off spacing
  parameter logic [15:0] REL_STEP  = REL_STEP_CYC   // 2.0 ms reset delay step
) (
  // Clock and reset (nrst is the core digital rail power-on reset)
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // One-time-programmed configuration
  input  wire logic [20:0] otp_powerup_slot,
  input  wire logic [2:0]  reset_release_delay_sel,
  input  wire logic        slot_period_sel,
  // Test-loaded configuration
  input  wire logic        test_loaded_config,
  input  wire logic [20:0] test_powerup_slot,
  // Rails and host signals
  output logic             rtc_supply_rail,
  output logic      [6:0]  reg_en,
  output logic             host_reset_out,
  output logic             powerup_done_flag,
  output logic             powerdown_done_flag
);

  // State
  rps_state_t  state_reg;          // Sequencer state
  rps_state_t  state_next;
  rps_state_t  dest_reg;           // Where power-down ends
  rps_state_t  dest_next;
  logic        init_done_reg;      // Slots captured after reset
  logic        rtc_on_reg;         // RTC supply rail enable
  logic [6:0]  reg_en_reg;         // Regulator enables
  logic [6:0]  work_set_reg;       // Outputs still to switch
  logic [6:0]  start_set;          // Set loaded on sequence entry
  logic        load_set;
  logic [2:0]  slot_cnt_reg;       // Current power-up slot
  logic        rel_pending_reg;    // Host reset still held from POR
  logic        rel_active_reg;     // Release delay running
  logic [9:0]  rel_cnt_reg;        // Release delay steps elapsed
  logic        host_rst_reg;       // Host reset level
  logic [6:0]  stby_en_reg;        // Outputs kept on in standby
  logic [6:0]  sleep_en_reg;       // Outputs kept on in sleep
  logic [20:0] pdn_slot_reg;       // Power-down slot settings
  logic        flag_up_reg;        // Power-up done, sticky
  logic        flag_dn_reg;        // Power-down done, sticky
  logic        set_flag_up;
  logic        set_flag_dn;
  logic [31:0] rdata_reg;          // Registered read data

  // Decode and helpers
  logic        req_valid;          // Mode request write
  logic [1:0]  req_mode;
  logic [20:0] up_slots;           // Active power-up slots
  logic [6:0]  up_match;
  logic [2:0]  up_max;
  logic [6:0]  dn_match;
  logic [2:0]  dn_max;
  logic [6:0]  dn_pick;            // Single output to turn off
  logic        pdn_all_zero;
  logic        up_done;
  logic        tick;
  logic        tick_restart;
  logic [15:0] tick_period;
  logic        sys_on;
  logic [4:0]  pdn_idx;

  assign req_valid    = reg_wr && (reg_addr == ADDR_CTRL);
  assign req_mode     = reg_wdata[1:0];
  assign up_slots     = test_loaded_config ? test_powerup_slot : otp_powerup_slot;
  assign pdn_all_zero = (pdn_slot_reg == 21'h00_0000);
  assign up_done      = ((work_set_reg & ~reg_en_reg) == 7'h00);
  assign dn_pick      = dn_match & (~dn_match + 7'h01);
  assign sys_on       = (state_reg == PS_RUN) || (state_reg == PS_STBY) || (state_reg == PS_SLEEP);
  assign pdn_idx      = 5'((reg_addr - ADDR_PDN_BASE) >> 2);

  // Slot compare for power-up (current count) and power-down (highest slot)
  rps_slot_match u_up_match (
    .slots    (up_slots),
    .mask     (work_set_reg),
    .cmp      (slot_cnt_reg),
    .match    (up_match),
    .max_slot (up_max)
  );

  rps_slot_match u_dn_match (
    .slots    (pdn_slot_reg),
    .mask     (work_set_reg),
    .cmp      (dn_max),
    .match    (dn_match),
    .max_slot (dn_max)
  );

  // Power-up uses the selected slot period; all other timing uses 2 ms
  always_comb begin
    if (state_reg == PS_UP) begin
      tick_period = slot_period_sel ? SLOT_SLOW : SLOT_FAST;
    end else if (state_reg == PS_DOWN) begin
      tick_period = PDN_GAP;
    end else begin
      tick_period = REL_STEP;
    end
  end

  // Each state change starts a fresh period
  assign tick_restart = (state_next != state_reg);

  rps_tick u_tick (
    .core_clk (core_clk),
    .nrst     (nrst),
    .restart  (tick_restart),
    .period   (tick_period),
    .tick     (tick)
  );

  // Next state; requests in transient states are ignored
  always_comb begin
    state_next  = state_reg;
    dest_next   = dest_reg;
    start_set   = 7'h00;
    load_set    = 1'b0;
    set_flag_up = 1'b0;
    set_flag_dn = 1'b0;
    unique case (state_reg)
      PS_OFF: begin
        // Regulators wait for the RTC rail to be up
        if (req_valid && req_mode == MODE_RUN && rtc_on_reg) begin
          state_next = PS_UP;
          start_set  = ALL_REGS;
          load_set   = 1'b1;
        end
      end
      PS_UP: begin
        if (up_done) begin
          state_next  = PS_RUN;
          set_flag_up = 1'b1;
        end
      end
      PS_RUN: begin
        if (req_valid) begin
          case (req_mode)
            MODE_STBY: begin
              if ((reg_en_reg & ~stby_en_reg) != 7'h00) begin
                state_next = PS_DOWN;
                dest_next  = PS_STBY;
                start_set  = reg_en_reg & ~stby_en_reg;
                load_set   = 1'b1;
              end else begin
                state_next  = PS_STBY;
                set_flag_dn = 1'b1;
              end
            end
            MODE_SLEEP: begin
              state_next = PS_DOWN;
              dest_next  = PS_SLEEP;
              start_set  = reg_en_reg & ~sleep_en_reg;
              load_set   = 1'b1;
            end
            MODE_OFF: begin
              state_next = PS_DOWN;
              dest_next  = PS_OFF;
              start_set  = reg_en_reg;
              load_set   = 1'b1;
            end
            default: begin
              state_next = PS_RUN;
            end
          endcase
        end
      end
      PS_DOWN: begin
        if (work_set_reg == 7'h00) begin
          state_next  = dest_reg;
          set_flag_dn = (dest_reg != PS_OFF);
        end
      end
      PS_STBY: begin
        if (req_valid && req_mode == MODE_RUN) begin
          start_set = ALL_REGS & ~reg_en_reg;
          load_set  = 1'b1;
          if ((ALL_REGS & ~reg_en_reg) != 7'h00) begin
            state_next = PS_UP;
          end else begin
            state_next  = PS_RUN;
            set_flag_up = 1'b1;
          end
        end else if (req_valid && req_mode == MODE_OFF) begin
          state_next = PS_DOWN;
          dest_next  = PS_OFF;
          start_set  = reg_en_reg;
          load_set   = 1'b1;
        end
      end
      PS_SLEEP: begin
        if (req_valid && req_mode == MODE_RUN) begin
          state_next = PS_UP;
          start_set  = ALL_REGS & ~reg_en_reg;
          load_set   = 1'b1;
        end else if (req_valid && req_mode == MODE_OFF) begin
          state_next = PS_DOWN;
          dest_next  = PS_OFF;
          start_set  = reg_en_reg;
          load_set   = 1'b1;
        end
      end
      default: begin
        // Illegal codes fall back to all-off
        state_next = PS_OFF;
      end
    endcase
  end

  // State registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= PS_OFF;
      dest_reg  <= PS_OFF;
    end else begin
      state_reg <= state_next;
      dest_reg  <= dest_next;
    end
  end

  // RTC rail comes up in the first cycle after POR, before any regulator
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      init_done_reg <= 1'b0;
      rtc_on_reg    <= 1'b0;
    end else begin
      init_done_reg <= 1'b1;
      rtc_on_reg    <= 1'b1;
    end
  end

  // Slot counter steps one slot per period up to the highest occupied slot
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      slot_cnt_reg <= 3'h0;
    end else if (load_set) begin
      slot_cnt_reg <= 3'h0;
    end else if (state_reg == PS_UP && tick && slot_cnt_reg < up_max) begin
      slot_cnt_reg <= slot_cnt_reg + 3'h1;
    end
  end

  // Work set and regulator enables
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      work_set_reg <= 7'h00;
      reg_en_reg   <= 7'h00;
    end else if (load_set) begin
      work_set_reg <= start_set;
    end else if (state_reg == PS_UP) begin
      reg_en_reg <= reg_en_reg | up_match;
    end else if (state_reg == PS_DOWN) begin
      if (pdn_all_zero) begin
        // Bypass: everything in the set goes off together
        reg_en_reg   <= reg_en_reg & ~work_set_reg;
        work_set_reg <= 7'h00;
      end else if (tick) begin
        // One output per gap, highest slot first, lowest index on a tie
        reg_en_reg   <= reg_en_reg & ~dn_pick;
        work_set_reg <= work_set_reg & ~dn_pick;
      end
    end
  end

  // Host reset: held from POR until power-up ends, then released after the delay
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      host_rst_reg    <= 1'b0;
      rel_pending_reg <= 1'b1;
      rel_active_reg  <= 1'b0;
      rel_cnt_reg     <= 10'h000;
    end else if (rel_pending_reg && state_reg == PS_UP && up_done) begin
      rel_active_reg <= 1'b1;
      rel_cnt_reg    <= 10'h000;
    end else if (rel_active_reg && tick) begin
      if (rel_cnt_reg + 10'h001 >= rps_rel_steps(reset_release_delay_sel)) begin
        host_rst_reg    <= 1'b1;
        rel_active_reg  <= 1'b0;
        rel_pending_reg <= 1'b0;
      end else begin
        rel_cnt_reg <= rel_cnt_reg + 10'h001;
      end
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flag_up_reg <= 1'b0;
      flag_dn_reg <= 1'b0;
    end else begin
      flag_up_reg <= set_flag_up ||
                     (flag_up_reg && !(reg_wr && reg_addr == ADDR_STATUS && reg_wdata[STAT_UP_BIT]));
      flag_dn_reg <= set_flag_dn ||
                     (flag_dn_reg && !(reg_wr && reg_addr == ADDR_STATUS && reg_wdata[STAT_DN_BIT]));
    end
  end

  // Masks for standby and sleep
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stby_en_reg  <= STBY_EN_RST;
      sleep_en_reg <= SLEEP_EN_RST;
    end else if (reg_wr && reg_addr == ADDR_STBY_EN) begin
      stby_en_reg <= reg_wdata[6:0];
    end else if (reg_wr && reg_addr == ADDR_SLEEP_EN) begin
      sleep_en_reg <= reg_wdata[6:0];
    end
  end

  // Power-down slots: copy power-up slots after POR, writable only when on.
  // The copy is clocked because an async reset may only load constants.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pdn_slot_reg <= 21'h00_0000;
    end else if (!init_done_reg) begin
      pdn_slot_reg <= up_slots;
    end else if (reg_wr && sys_on && reg_addr >= ADDR_PDN_BASE && reg_addr <= ADDR_PDN_LAST &&
                 reg_addr[1:0] == 2'b00) begin
      pdn_slot_reg[pdn_idx*SLOT_W +: SLOT_W] <= reg_wdata[2:0];
    end
  end

  // Read data, valid the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_reg <= 32'h0000_0000;
      if (reg_addr == ADDR_CTRL) begin
        rdata_reg[2:0] <= state_reg;
      end else if (reg_addr == ADDR_STATUS) begin
        rdata_reg[STAT_UP_BIT]  <= flag_up_reg;
        rdata_reg[STAT_DN_BIT]  <= flag_dn_reg;
        rdata_reg[STAT_RST_BIT] <= host_rst_reg;
        rdata_reg[STAT_RTC_BIT] <= rtc_on_reg;
        rdata_reg[14:8]         <= reg_en_reg;
      end else if (reg_addr == ADDR_STBY_EN) begin
        rdata_reg[6:0] <= stby_en_reg;
      end else if (reg_addr == ADDR_SLEEP_EN) begin
        rdata_reg[6:0] <= sleep_en_reg;
      end else if (reg_addr >= ADDR_PDN_BASE && reg_addr <= ADDR_PDN_LAST && reg_addr[1:0] == 2'b00) begin
        rdata_reg[2:0] <= pdn_slot_reg[pdn_idx*SLOT_W +: SLOT_W];
      end
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // Outputs
  assign reg_rdata           = rdata_reg;
  assign rtc_supply_rail     = rtc_on_reg;
  assign reg_en              = reg_en_reg;
  assign host_reset_out      = host_rst_reg;
  assign powerup_done_flag   = flag_up_reg;
  assign powerdown_done_flag = flag_dn_reg;

endmodule // rps_sequencer

/* bench/rps_sequencer_properties.sv */
// Concurrent checks on the sequencer ports, bound into every instance
`timescale 1ns/1ps
module rps_seq_properties
  import rps_pkg::*;
#(
  parameter logic [15:0] SLOT_FAST = SLOT_FAST_CYC, // Shortest slot period
  parameter logic [15:0] PDN_GAP   = PDN_GAP_CYC,   // Turn-off spacing
  parameter logic [15:0] REL_STEP  = REL_STEP_CYC   // Reset release step
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // Register port
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Rails and host signals
  input wire logic        rtc_supply_rail,
  input wire logic [6:0]  reg_en,
  input wire logic        host_reset_out
);
  logic [6:0]  prev_en_reg; // Enables one cycle back
  logic [15:0] off_cnt_reg; // Cycles since the last turn-off
  logic [15:0] on_cnt_reg;  // Cycles since the last turn-on
  logic [6:0]  off_b;       // Outputs that just went off
  logic [6:0]  on_b;        // Outputs that just came on
  assign off_b = prev_en_reg & ~reg_en;
  assign on_b  = reg_en & ~prev_en_reg;
  // Previous enables
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prev_en_reg <= 7'h00;
    end else begin
      prev_en_reg <= reg_en;
    end
  end
  // Counters start saturated so the first event after reset is never judged
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      off_cnt_reg <= 16'hffff;
    end else if (|off_b) begin
      off_cnt_reg <= 16'h0000;
    end else if (off_cnt_reg != 16'hffff) begin
      off_cnt_reg <= off_cnt_reg + 16'h0001;
    end
  end
  // Turn-on distance counter
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      on_cnt_reg <= 16'hffff;
    end else if (|on_b) begin
      on_cnt_reg <= 16'h0000;
    end else if (on_cnt_reg != 16'hffff) begin
      on_cnt_reg <= on_cnt_reg + 16'h0001;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_rail_first;
    |reg_en |-> rtc_supply_rail;
  endproperty
  a_rail_first: assert property (p_rail_first) else $error("regulator on without rtc rail");
  property p_rtc_rise;
    $rose(rtc_supply_rail) |-> reg_en == 7'h00 && !host_reset_out;
  endproperty
  a_rtc_rise: assert property (p_rtc_rise) else $error("rtc rail not first");
  property p_host_low;
    !rtc_supply_rail |-> !host_reset_out;
  endproperty
  a_host_low: assert property (p_host_low) else $error("host reset lifted without rails");
  property p_rel_after_up;
    $rose(host_reset_out) |-> reg_en != 7'h00;
  endproperty
  a_rel_after_up: assert property (p_rel_after_up) else $error("host reset lifted before power-up");
  property p_rel_delay;
    $rose(host_reset_out) |-> on_cnt_reg >= REL_STEP - 16'h0001;
  endproperty
  a_rel_delay: assert property (p_rel_delay) else $error("host reset lifted too early");
  property p_off_single;
    |off_b |-> $onehot(off_b) || reg_en == 7'h00;
  endproperty
  a_off_single: assert property (p_off_single) else $error("several outputs off at once");
  property p_off_gap;
    |off_b |-> off_cnt_reg >= PDN_GAP - 16'h0001;
  endproperty
  a_off_gap: assert property (p_off_gap) else $error("turn-offs too close");
  property p_on_gap;
    |on_b |-> on_cnt_reg >= SLOT_FAST - 16'h0001;
  endproperty
  a_on_gap: assert property (p_on_gap) else $error("turn-ons closer than a slot");
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
endmodule // rps_seq_properties

bind rps_sequencer rps_seq_properties #(
  .SLOT_FAST(SLOT_FAST),
  .PDN_GAP(PDN_GAP),
  .REL_STEP(REL_STEP)
) u_props (
  .core_clk(core_clk),
  .nrst(nrst),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .rtc_supply_rail(rtc_supply_rail),
  .reg_en(reg_en),
  .host_reset_out(host_reset_out)
);

/* bench/rps_host_model.sv */
// Processor-side model: counts boots and completed power-ups
`timescale 1ns/1ps
module rps_host_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // From the sequencer
  input  wire logic       host_reset_out,
  input  wire logic       powerup_done_flag,
  // Observed counts
  output logic      [7:0] boot_count,
  output logic      [7:0] wake_count
);
  logic rst_reg, flag_reg; // Reset line and flag one cycle back
  // A second boot would mean the host was reset during a later wake
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_reg    <= 1'b0;
      flag_reg   <= 1'b0;
      boot_count <= 8'h00;
      wake_count <= 8'h00;
    end else begin
      rst_reg  <= host_reset_out;
      flag_reg <= powerup_done_flag;
      if (host_reset_out && !rst_reg) begin
        boot_count <= boot_count + 8'h01;
      end
      if (powerup_done_flag && !flag_reg) begin
        wake_count <= wake_count + 8'h01;
      end
    end
  end
endmodule // rps_host_model

/* bench/test_regulator_power_sequencer.sv */
// Self-checking bench for the regulator power sequencer
`timescale 1ns/1ps
module test_regulator_power_sequencer
  import rps_pkg::*;
();
  localparam logic [15:0] T_FAST = 16'h0004;     // Short timing keeps the run brief
  localparam logic [15:0] T_SLOW = 16'h0008;
  localparam logic [15:0] T_GAP  = 16'h0008;
  localparam logic [15:0] T_REL  = 16'h0008;
  localparam logic [20:0] OTP_SL = 21'h1_b315;   // Slots 5,2,4,1,3,3,0
  localparam logic [20:0] TST_SL = 21'h1a_c688;  // Slot i for output i
  logic        core_clk, nrst, reg_wr, reg_rd, slot_period_sel, test_loaded_config;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        rtc_supply_rail, host_reset_out, powerup_done_flag, powerdown_done_flag;
  logic [6:0]  reg_en;
  logic [7:0]  boot_count, wake_count;
  int          fails, comparisons;
  rps_sequencer #(.SLOT_FAST(T_FAST), .SLOT_SLOW(T_SLOW), .PDN_GAP(T_GAP), .REL_STEP(T_REL)) dut_u (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_powerup_slot(OTP_SL),
    .reset_release_delay_sel(3'h1), .slot_period_sel(slot_period_sel),
    .test_loaded_config(test_loaded_config), .test_powerup_slot(TST_SL),
    .rtc_supply_rail(rtc_supply_rail), .reg_en(reg_en), .host_reset_out(host_reset_out),
    .powerup_done_flag(powerup_done_flag), .powerdown_done_flag(powerdown_done_flag));
  rps_host_model host_u (.core_clk(core_clk), .nrst(nrst), .host_reset_out(host_reset_out),
    .powerup_done_flag(powerup_done_flag), .boot_count(boot_count), .wake_count(wake_count));
  always #20 core_clk = ~core_clk;
  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // True when a higher-slot output is on while a lower one is off
  function automatic logic misordered(input logic [6:0] en, input logic [20:0] s);
    logic bad;
    bad = 1'b0;
    for (int a = 0; a < 7; a++) begin
      for (int b = 0; b < 7; b++) begin
        if (en[a] && !en[b] && s[3*a+:3] > s[3*b+:3]) bad = 1'b1;
      end
    end
    return bad;
  endfunction
  // Clear both flags, request a mode and watch the enables until the matching flag rises
  task automatic run_to(input logic [1:0] mode, input logic [20:0] s, input logic dn, output int cyc);
    logic bad;
    bad = 1'b0;
    cyc = 0;
    wr(ADDR_STATUS, 32'h3);
    wr(ADDR_CTRL, {30'h0, mode});
    #1;
    while (!(dn ? powerdown_done_flag : powerup_done_flag) && cyc < 2000) begin
      @(posedge core_clk);
      #1;
      cyc++;
      if (misordered(reg_en, s)) bad = 1'b1;
    end
    chk("order", 32'h0, {31'h0, bad});
    chk("done flag", 32'h1, {31'h0, dn ? powerdown_done_flag : powerup_done_flag});
  endtask
  task automatic t_reset;
    logic [31:0] d;
    chk("rtc rail", 32'h1, {31'h0, rtc_supply_rail});
    chk("host reset", 32'h0, {31'h0, host_reset_out});
    for (int i = 0; i < 7; i++) begin
      rd(ADDR_PDN_BASE + 8'(4 * i), d);
      chk("pdn default", {29'h0, OTP_SL[3*i+:3]}, d);
    end
    rd(8'h2c, d);
    chk("unmapped", 32'h0, d);
    $display("test reset done");
  endtask
  task automatic t_powerup;
    int cyc;
    run_to(MODE_RUN, OTP_SL, 1'b0, cyc);
    chk("slot time", 32'h1, {31'h0, cyc >= 5 * T_FAST});
    chk("all on", 32'h7f, {25'h0, reg_en});
    chk("host held", 32'h0, {31'h0, host_reset_out});
    cyc = 0;
    while (!host_reset_out && cyc < 200) begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
    chk("release delay", 32'h1, {31'h0, cyc >= 2 * T_REL - 1 && cyc <= 2 * T_REL + 1});
    $display("test power-up done");
  endtask
  task automatic t_sleep;
    logic [31:0] d;
    int          cyc;
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_PDN_BASE + 8'(4 * i), 32'(i));
    end
    rd(ADDR_PDN_BASE + 8'h18, d);
    chk("pdn write", 32'h6, d);
    run_to(MODE_SLEEP, TST_SL, 1'b1, cyc);
    chk("gap time", 32'h1, {31'h0, cyc >= 7 * T_GAP - 1});
    chk("all off", 32'h0, {25'h0, reg_en});
    rd(ADDR_CTRL, d);
    chk("state", {29'h0, PS_SLEEP}, {29'h0, d[2:0]});
    $display("test sleep done");
  endtask
  task automatic t_wake;
    int cyc;
    @(posedge core_clk);
    test_loaded_config <= 1'b1;
    slot_period_sel    <= 1'b1;
    run_to(MODE_RUN, TST_SL, 1'b0, cyc);
    chk("slow slot time", 32'h1, {31'h0, cyc >= 6 * T_SLOW});
    chk("all on", 32'h7f, {25'h0, reg_en});
    chk("host stays up", 32'h1, {31'h0, host_reset_out});
    $display("test wake done");
  endtask
  task automatic t_standby;
    logic [31:0] d;
    int          cyc;
    run_to(MODE_STBY, TST_SL, 1'b1, cyc);
    chk("standby quick", 32'h1, {31'h0, cyc <= 3});
    chk("kept on", 32'h7f, {25'h0, reg_en});
    rd(ADDR_CTRL, d);
    chk("state", {29'h0, PS_STBY}, {29'h0, d[2:0]});
    run_to(MODE_RUN, TST_SL, 1'b0, cyc);
    chk("resume quick", 32'h1, {31'h0, cyc <= 3});
    wr(ADDR_STBY_EN, 32'h0f);
    run_to(MODE_STBY, TST_SL, 1'b1, cyc);
    chk("partial standby", 32'h0f, {25'h0, reg_en});
    run_to(MODE_RUN, TST_SL, 1'b0, cyc);
    chk("standby wake", 32'h7f, {25'h0, reg_en});
    $display("test standby done");
  endtask
  task automatic t_bypass;
    int cyc;
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_PDN_BASE + 8'(4 * i), 32'h0);
    end
    run_to(MODE_SLEEP, 21'h0, 1'b1, cyc);
    chk("bypass quick", 32'h1, {31'h0, cyc <= 3});
    chk("all off", 32'h0, {25'h0, reg_en});
    chk("boots", 32'h1, {24'h0, boot_count});
    chk("wakes", 32'h4, {24'h0, wake_count});
    $display("test bypass done");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    core_clk           = 1'b0;
    nrst               <= 1'b0;
    reg_addr           <= 8'h00;
    reg_wdata          <= 32'h0;
    reg_wr             <= 1'b0;
    reg_rd             <= 1'b0;
    slot_period_sel    <= 1'b0;
    test_loaded_config <= 1'b0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    t_reset;
    t_powerup;
    t_sleep;
    t_wake;
    t_standby;
    t_bypass;
    give_verdict;
  end
  // Watchdog
  initial begin
    #(40 * 5000);
    fails++;
    give_verdict;
  end
endmodule // test_regulator_power_sequencer
